// ===== pkg/gpt4_pkg.sv
// Constants and helpers shared by the general-purpose timer four block
// How it works
// - Capture enable bit 17 set takes event captures; cleared disables them.
// - Five-bit field 16..12 picks which of events 0..31 triggers capture.
// - Clock select 000 oscillator, 001 core clock, 010 and 011 undivided PLL.
// - Direction bit 8 set counts up; cleared, the reset state, counts down.
// - Timer runs only while enable bit 7 is one; resets to zero.
// - Mode bit 6 one is periodic, zero free-running, zero at reset.
// - Format 10 keeps hours:minutes:seconds:hundredths, hours 23 down to 0.
// - Format 11 keeps hours:minutes:seconds:hundredths, hours 255 down to 0.
// - Prescaler divides source by 2 to the code: 1, 16, 256, 32768.
// - Loss of PLL lock gates the core clock off until lock returns.
// - Counter reloads from load register on wrap in periodic mode and at once on refresh.
// - Each rising edge of selected event copies count into capture register.
// - Any write to the interrupt clear register clears the pending timeout, except that a wrap in the same cycle sets it.
// - Load, value and capture are 32-bit; value and capture read only.

`default_nettype none

package gpt4_pkg;

  // ----------------------------------------
  // Bus and register layout
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CFG_W = 18;
  localparam int IRQ_W = 2;
  localparam int CLK_SEL_W = 3;
  localparam int PRE_CODE_W = 4;
  localparam int PRE_W = 15;

  localparam logic [7:0] OFS_RELOAD = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_REFRESH = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // ----------------------------------------
  // Config field positions
  // ----------------------------------------
  localparam int CFG_CAP_EN = 17;
  localparam int CFG_EVT_LO = 12;
  localparam int CFG_CLK_LO = 9;
  localparam int CFG_UP = 8;
  localparam int CFG_EN = 7;
  localparam int CFG_PER = 6;
  localparam int CFG_FMT_LO = 4;
  localparam int CFG_PRE_LO = 0;

  localparam int IRQ_TMO = 0;
  localparam int IRQ_CAP = 1;

  // ----------------------------------------
  // Codes and limits
  // ----------------------------------------
  localparam logic [2:0] SRC_OSC = 3'h0;
  localparam logic [2:0] SRC_CORE = 3'h1;
  localparam logic [2:0] SRC_PLL_A = 3'h2;
  localparam logic [2:0] SRC_PLL_B = 3'h3;

  localparam logic [1:0] FMT_BIN = 2'h0;
  localparam logic [1:0] FMT_RSVD = 2'h1;
  localparam logic [1:0] FMT_H23 = 2'h2;
  localparam logic [1:0] FMT_H255 = 2'h3;

  localparam logic [7:0] HOUR_MAX_23 = 8'h17;
  localparam logic [7:0] HOUR_MAX_255 = 8'hff;
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] HUND_MAX = 8'h63;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [17:0] CFG_RST = 18'h0;
  localparam logic [31:0] RELOAD_RST = 32'h00000000;
  localparam logic [31:0] COUNT_RST = 32'h00000000;
  localparam logic [31:0] CAP_RST = 32'h00000000;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Prescaler mask: divide by two to the code
  function automatic logic [14:0] gpt4_pre_mask(input logic [3:0] code);
    return 15'((32'h1 << code) - 32'h1);
  endfunction

endpackage

`default_nettype wire

// ===== hw/gpt4_prescale.sv
// Source clock selection and prescaler for timer four
`timescale 1ns/1ns
`default_nettype none

module gpt4_prescale (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [gpt4_pkg::CLK_SEL_W-1:0] clk_sel_in,
  input wire logic [gpt4_pkg::PRE_CODE_W-1:0] pre_in,
  input wire logic run_in,
  input wire logic osc_in,
  input wire logic pll_in,
  output logic tick_out
);
  import gpt4_pkg::*;

  logic osc_q;
  logic pll_q;
  logic src_pulse;
  logic [PRE_W-1:0] div;
  logic [PRE_W-1:0] mask;

  // ----------------------------------------
  // Source edge detect
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      osc_q <= 1'b0;
      pll_q <= 1'b0;
    end else begin
      osc_q <= osc_in;
      pll_q <= pll_in;
    end
  end

  always_comb begin
    case (clk_sel_in)
      SRC_OSC: src_pulse = osc_in & ~osc_q;
      SRC_CORE: src_pulse = 1'b1;
      SRC_PLL_A, SRC_PLL_B: src_pulse = pll_in & ~pll_q;
      default: src_pulse = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  assign mask = gpt4_pre_mask(pre_in);
  assign tick_out = run_in && src_pulse && ((div & mask) == mask);

  always_ff @(posedge clk_in) begin
    if (!resetn_in || !run_in) begin
      div <= '0;
    end else if (src_pulse) begin
      if (tick_out) begin
        div <= '0;
      end else begin
        div <= div + 15'h0001;
      end
    end
  end

endmodule

`default_nettype wire

// ===== hw/gpt4_timer.sv
// General-purpose timer four: registers, counter, capture, interrupt
`timescale 1ns/1ns
`default_nettype none

module gpt4_timer (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [gpt4_pkg::ADDR_W-1:0] addr_in,
  input wire logic [gpt4_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [gpt4_pkg::DATA_W-1:0] rdata_out,
  input wire logic osc_clk_in,
  input wire logic undivided_pll_clock_in,
  input wire logic pll_lock_in,
  input wire logic [31:0] event_in,
  output logic irq_out,
  output logic core_clock_enable_out
);
  import gpt4_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [CFG_W-1:0] cfg;
  logic [31:0] reload;
  logic [31:0] count;
  logic [31:0] cap;
  logic [31:0] next_count;
  logic [31:0] step;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] stat;
  logic [IRQ_W-1:0] mask;
  logic [IRQ_W-1:0] next_stat;
  logic tick;
  logic up;
  logic run;
  logic periodic;
  logic hms;
  logic at_end;
  logic wrap_evt;
  logic evt_q;
  logic evt_now;
  logic evt_rise;
  logic do_cap;
  logic refresh_wr;
  logic iclr_wr;
  logic [1:0] fmt;
  logic [4:0] evt_sel;
  logic [7:0] hmax;

  // ----------------------------------------
  // Time-format step
  // ----------------------------------------
  function automatic logic [31:0] hms_step(
    input logic [31:0] c,
    input logic dir_up,
    input logic [7:0] hlim
  );
    logic [7:0] h;
    logic [7:0] m;
    logic [7:0] s;
    logic [7:0] f;
    h = c[31:24];
    m = c[23:16];
    s = c[15:8];
    f = c[7:0];
    if (dir_up) begin
      if (f >= HUND_MAX) begin
        f = 8'h00;
        if (s >= SEC_MAX) begin
          s = 8'h00;
          if (m >= SEC_MAX) begin
            m = 8'h00;
            h = (h >= hlim) ? 8'h00 : h + 8'h01;
          end else begin
            m = m + 8'h01;
          end
        end else begin
          s = s + 8'h01;
        end
      end else begin
        f = f + 8'h01;
      end
    end else begin
      if (f == 8'h00) begin
        f = HUND_MAX;
        if (s == 8'h00) begin
          s = SEC_MAX;
          if (m == 8'h00) begin
            m = SEC_MAX;
            h = (h == 8'h00) ? hlim : h - 8'h01;
          end else begin
            m = m - 8'h01;
          end
        end else begin
          s = s - 8'h01;
        end
      end else begin
        f = f - 8'h01;
      end
    end
    return {h, m, s, f};
  endfunction

  // ----------------------------------------
  // Config decode
  // ----------------------------------------
  // Upper config bits are not stored and read as zero
  assign up = cfg[CFG_UP];
  assign run = cfg[CFG_EN];
  assign periodic = cfg[CFG_PER];
  assign fmt = cfg[CFG_FMT_LO +: 2];
  assign evt_sel = cfg[CFG_EVT_LO +: 5];
  assign hms = fmt[1];
  assign hmax = (fmt == FMT_H23) ? HOUR_MAX_23 : HOUR_MAX_255;
  assign refresh_wr = wr_in && (addr_in == OFS_REFRESH);
  assign iclr_wr = wr_in && (addr_in == OFS_IRQ_CLEAR);

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  gpt4_prescale u_pre (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clk_sel_in(cfg[CFG_CLK_LO +: CLK_SEL_W]),
    .pre_in(cfg[CFG_PRE_LO +: PRE_CODE_W]),
    .run_in(run),
    .osc_in(osc_clk_in),
    .pll_in(undivided_pll_clock_in),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    if (hms) begin
      at_end = up ? (count == {hmax, SEC_MAX, SEC_MAX, HUND_MAX}) : (count == 32'h0);
      step = hms_step(count, up, hmax);
    end else begin
      at_end = up ? (&count) : (count == 32'h0);
      step = up ? count + 32'h1 : count - 32'h1;
    end
  end

  assign wrap_evt = tick && at_end;

  always_comb begin
    next_count = count;
    if (refresh_wr) begin
      next_count = reload;
    end else if (wrap_evt && periodic) begin
      next_count = reload;
    end else if (tick) begin
      next_count = step;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count <= COUNT_RST;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------
  // Config and load registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cfg <= CFG_RST;
    end else if (wr_in && addr_in == OFS_CONFIG) begin
      cfg <= wdata_in[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      reload <= RELOAD_RST;
    end else if (wr_in && addr_in == OFS_RELOAD) begin
      reload <= wdata_in;
    end
  end

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  assign evt_now = event_in[evt_sel];
  assign evt_rise = evt_now && !evt_q;
  assign do_cap = cfg[CFG_CAP_EN] && evt_rise;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= evt_now;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cap <= CAP_RST;
    end else if (do_cap) begin
      cap <= count;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    next_stat = stat;
    if (iclr_wr) begin
      next_stat[IRQ_TMO] = 1'b0;
    end
    if (wr_in && addr_in == OFS_IRQ_STATUS) begin
      next_stat = next_stat & ~wdata_in[IRQ_W-1:0];
    end
    if (wrap_evt) begin
      next_stat[IRQ_TMO] = 1'b1;
    end
    if (do_cap) begin
      next_stat[IRQ_CAP] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stat <= IRQ_RST;
    end else begin
      stat <= next_stat;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mask <= IRQ_RST;
    end else if (wr_in && addr_in == OFS_IRQ_MASK) begin
      mask <= wdata_in[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat & mask);
    end
  end

  // ----------------------------------------
  // Core clock gate
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      core_clock_enable_out <= 1'b0;
    end else begin
      core_clock_enable_out <= pll_lock_in;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    case (addr_in)
      OFS_RELOAD: rd_mux = reload;
      OFS_COUNT: rd_mux = count;
      OFS_CONFIG: rd_mux = {14'h0, cfg};
      OFS_CAPTURE: rd_mux = cap;
      OFS_IRQ_STATUS: rd_mux = {30'h0, stat};
      OFS_IRQ_MASK: rd_mux = {30'h0, mask};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= rd_in ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_hold_off;
    !run && !refresh_wr |=> $stable(count);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("count moved while disabled");

  property p_refresh;
    refresh_wr |=> count == $past(reload);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh did not reload");

  property p_capture;
    cfg[CFG_CAP_EN] && evt_rise |=> cap == $past(count);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture missed count");

  property p_cap_off;
    !cfg[CFG_CAP_EN] |=> $stable(cap);
  endproperty
  a_cap_off: assert property (p_cap_off)
    else $error("capture while disabled");

  property p_iclr;
    iclr_wr && !wrap_evt |=> !stat[IRQ_TMO];
  endproperty
  a_iclr: assert property (p_iclr)
    else $error("timeout flag not cleared");

  property p_div1;
    run && cfg[CFG_CLK_LO +: 3] == SRC_CORE && cfg[3:0] == 4'h0
      && !refresh_wr |-> tick;
  endproperty
  a_div1: assert property (p_div1)
    else $error("core source at divide 1 missed tick");

  property p_up_bin;
    tick && up && !hms && !at_end && !refresh_wr
      |=> count == $past(count) + 32'h1;
  endproperty
  a_up_bin: assert property (p_up_bin)
    else $error("binary up step wrong");

  property p_periodic;
    wrap_evt && periodic && !refresh_wr |=> count == $past(reload);
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("periodic reload missing");

  property p_gate;
    !pll_lock_in |=> !core_clock_enable_out;
  endproperty
  a_gate: assert property (p_gate)
    else $error("core clock not gated");

endmodule

`default_nettype wire

// ===== bench/tb_gpt4_timer.sv
// Self-checking testbench for general-purpose timer four
`timescale 1ns/1ns
`default_nettype none

module tb_gpt4_timer;
  import gpt4_pkg::*;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = 8'h00;
  logic [DATA_W-1:0] wdata_in = 32'h00000000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic osc_in = 1'b0;
  logic pll_in = 1'b0;
  logic lock_in = 1'b1;
  logic [31:0] event_in = 32'h00000000;
  logic irq_out;
  logic ce_out;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  logic [31:0] seed = 32'h0001550f;
  logic [31:0] r;
  logic [31:0] q;
  logic [4:0] s;
  logic [7:0] offs [9];
  logic [31:0] tst [5];
  logic [1:0] tfm [5];
  logic [4:0] tup;
  logic [3:0] pre [3];
  int edg [3];
  int tk [3];

  gpt4_timer dut (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .osc_clk_in(osc_in),
    .undivided_pll_clock_in(pll_in),
    .pll_lock_in(lock_in),
    .event_in(event_in),
    .irq_out(irq_out),
    .core_clock_enable_out(ce_out)
  );

  always #25 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] mk(input logic cap, input logic [4:0] sel,
      input logic [2:0] src, input logic up, input logic en, input logic per,
      input logic [1:0] fmt, input logic [3:0] pr);
    return {14'h0, cap, sel, src, up, en, per, fmt, pr};
  endfunction

  // Next count after one tick
  function automatic logic [31:0] step(input logic [31:0] c, input logic up,
      input logic [1:0] fmt, input logic per, input logic [31:0] ld);
    logic [31:0] top;
    logic [31:0] t;
    logic [7:0] lim;
    top = fmt[1] ? {(fmt == FMT_H255) ? 8'hff : 8'h17, 8'h3b, 8'h3b, 8'h63} : 32'hffffffff;
    if (up && c == top) return per ? ld : 32'h00000000;
    if (!up && c == 32'h00000000) return per ? ld : top;
    if (!fmt[1]) return up ? c + 32'h1 : c - 32'h1;
    t = c;
    for (int k = 0; k < 3; k++) begin
      lim = (k == 0) ? 8'h63 : 8'h3b;
      if (t[8*k+:8] != (up ? lim : 8'h00)) begin
        t[8*k+:8] = up ? t[8*k+:8] + 8'h01 : t[8*k+:8] - 8'h01;
        return t;
      end
      t[8*k+:8] = up ? 8'h00 : lim;
    end
    t[31:24] = up ? t[31:24] + 8'h01 : t[31:24] - 8'h01;
    return t;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
    @(posedge clk_in);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic pulse(input logic pll, input int m);
    repeat (m) begin
      if (pll) osc_in <= 1'b0;
      else osc_in <= 1'b1;
      pll_in <= pll;
      @(posedge clk_in);
      osc_in <= 1'b0;
      pll_in <= 1'b0;
      @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask

  // Load, tick through source edges, freeze, compare with the model
  task automatic run(input logic [31:0] cfg, input logic [31:0] ld, input int m,
      input logic pll, input int ticks);
    logic [31:0] e;
    e = ld;
    wr(OFS_RELOAD, ld);
    wr(OFS_REFRESH, rnd());
    rc(OFS_COUNT, ld);
    wr(OFS_CONFIG, cfg);
    pulse(pll, m);
    wr(OFS_CONFIG, cfg & 32'hffffff7f);
    repeat (ticks) e = step(e, cfg[CFG_UP], cfg[CFG_FMT_LO+:2], cfg[CFG_PER], ld);
    rc(OFS_COUNT, e);
  endtask

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    offs = '{OFS_RELOAD, OFS_COUNT, OFS_CONFIG, OFS_REFRESH, OFS_CAPTURE,
             OFS_IRQ_CLEAR, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h20};
    tst = '{32'h173b3b63, 32'h173b3b63, 32'h00000000, 32'h01000000, 32'hfe3b3b62};
    tfm = '{FMT_H23, FMT_H255, FMT_H23, FMT_H255, FMT_H255};
    tup = 5'b10011;
    pre = '{4'h4, 4'h8, 4'hf};
    edg = '{32, 512, 32768};
    tk = '{2, 2, 1};
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 9; i++) rc(offs[i], 32'h00000000);
    chk({31'h0, ce_out}, 32'h1);
    lock_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({31'h0, ce_out}, 32'h0);
    lock_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({31'h0, ce_out}, 32'h1);
    wr(OFS_CONFIG, 32'h0003ffff);
    rc(OFS_CONFIG, 32'h0003ffff);
    wr(OFS_CONFIG, 32'h00000000);
    r = rnd();
    wr(OFS_RELOAD, r);
    wr(OFS_COUNT, 32'h12345678);
    wr(OFS_CAPTURE, 32'h12345678);
    rc(OFS_RELOAD, r);
    rc(OFS_COUNT, 32'h00000000);
    rc(OFS_CAPTURE, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      r = i[2] ? (i[0] ? 32'hfffffffe : 32'h00000001) : rnd();
      n = i[2] ? 3 : 1 + int'(rnd() & 32'h7);
      q = mk(1'b0, 5'h00, SRC_OSC, i[0], 1'b1, i[1], i[1] ? FMT_RSVD : FMT_BIN, 4'h0);
      run(q, r, n, 1'b0, n);
    end
    rc(OFS_IRQ_STATUS, 32'h00000001);
    wr(OFS_IRQ_CLEAR, rnd());
    rc(OFS_IRQ_STATUS, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      q = mk(1'b0, 5'h00, SRC_OSC, tup[i], 1'b1, 1'b0, tfm[i], 4'h0);
      run(q, tst[i], 2, 1'b0, 2);
    end
    q = mk(1'b0, 5'h00, SRC_PLL_A, 1'b1, 1'b1, 1'b0, FMT_BIN, 4'h0);
    run(q, rnd(), 5, 1'b1, 5);
    q = mk(1'b0, 5'h00, SRC_PLL_B, 1'b0, 1'b1, 1'b0, FMT_BIN, 4'h0);
    run(q, rnd(), 4, 1'b1, 4);
    q = mk(1'b0, 5'h00, SRC_OSC, 1'b1, 1'b1, 1'b0, FMT_BIN, 4'h0);
    run(q, rnd(), 4, 1'b1, 0);
    q = mk(1'b0, 5'h00, 3'h4, 1'b1, 1'b1, 1'b0, FMT_BIN, 4'h0);
    run(q, rnd(), 4, 1'b0, 0);
    q = mk(1'b0, 5'h00, SRC_OSC, 1'b1, 1'b0, 1'b0, FMT_BIN, 4'h0);
    run(q, rnd(), 4, 1'b0, 0);
    wr(OFS_CONFIG, mk(1'b0, 5'h00, SRC_CORE, 1'b1, 1'b1, 1'b0, FMT_BIN, 4'h0));
    rd(OFS_COUNT, r);
    rd(OFS_COUNT, q);
    chk(q - r, 32'h00000002);
    // Stop the free-running core count before the next load
    wr(OFS_CONFIG, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      q = mk(1'b0, 5'h00, SRC_OSC, 1'b0, 1'b1, 1'b0, FMT_BIN, pre[i]);
      run(q, rnd(), edg[i], 1'b0, tk[i]);
    end
    r = rnd();
    s = r[4:0];
    wr(OFS_RELOAD, r);
    wr(OFS_REFRESH, 32'h00000000);
    wr(OFS_IRQ_STATUS, 32'h00000003);
    wr(OFS_IRQ_MASK, 32'h00000000);
    wr(OFS_CONFIG, mk(1'b1, s, SRC_CORE, 1'b0, 1'b0, 1'b0, FMT_BIN, 4'h0));
    event_in <= 32'hffffffff ^ (32'h1 << s);
    repeat (3) @(posedge clk_in);
    rc(OFS_IRQ_STATUS, 32'h00000000);
    event_in <= 32'hffffffff;
    repeat (3) @(posedge clk_in);
    rc(OFS_CAPTURE, r);
    rc(OFS_IRQ_STATUS, 32'h00000002);
    chk({31'h0, irq_out}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h00000003);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h00000002);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    event_in <= 32'h00000000;
    wr(OFS_CONFIG, mk(1'b0, s, SRC_CORE, 1'b0, 1'b0, 1'b0, FMT_BIN, 4'h0));
    event_in <= 32'hffffffff;
    repeat (3) @(posedge clk_in);
    rc(OFS_IRQ_STATUS, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
